// *** bcs_pkg.sv ***
// Package of states, widths and encodings for the bus cycle sequencer
package bcs_pkg;

	localparam int ADDR_HI = 31;
	localparam int ADDR_LO = 3;
	localparam int DATA_W = 64;
	localparam int BE_W = 8;
	localparam int PAR_W = 8;
	localparam logic [2:0] BURST_BEATS = 3'h4;
	localparam logic [2:0] SINGLE_BEATS = 3'h1;
	localparam int SLOT_W = 112;

	typedef enum logic [2:0] {
		BCS_IDLE = 3'b000,
		BCS_ADDR = 3'b001,
		BCS_DATA = 3'b011,
		BCS_NAREQ = 3'b010,
		BCS_PADDR = 3'b110,
		BCS_PDATA = 3'b111,
		BCS_TURN = 3'b101
	} bcs_state_e;

endpackage : bcs_pkg

// *** bcs_slot_mem.sv ***
// Two-entry register memory holding the descriptors of outstanding cycles
module bcs_slot_mem #(
	parameter int WIDTH = bcs_pkg::SLOT_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [2];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Write-through so a slot written this cycle is read correctly next cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= '0;
		end else if (wr_en && wr_addr == rd_addr) begin
			rd_data <= wr_data;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : bcs_slot_mem

// *** bcs_sequencer.sv ***
// Local-bus cycle sequencer: state machine, pipelining, split cycles, cache handshake
module bcs_sequencer #(
	parameter int DATA_W = bcs_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic resetn,
	// Core request side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [bcs_pkg::ADDR_HI:bcs_pkg::ADDR_LO] req_addr,
	input wire logic [bcs_pkg::BE_W-1:0] req_be,
	input wire logic [bcs_pkg::BE_W-1:0] req_be_hi,
	input wire logic req_split,
	input wire logic req_write,
	input wire logic req_code,
	input wire logic req_mem,
	input wire logic req_cache,
	input wire logic req_pcd,
	input wire logic req_pwt,
	input wire logic req_serialize,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [DATA_W-1:0] req_wdata_hi,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic [bcs_pkg::PAR_W-1:0] rsp_parity,
	output logic rsp_cacheable,
	output logic rsp_writeback,
	output logic rsp_last,
	// Bus side, active-low pins named with _n
	output logic address_strobe_n,
	output logic [bcs_pkg::ADDR_HI:bcs_pkg::ADDR_LO] addr_out,
	output logic addr_oe,
	output logic [bcs_pkg::BE_W-1:0] byte_enables_n,
	output logic data_code_select,
	output logic write_read_select,
	output logic memory_io_select,
	output logic cacheable_intent_n,
	output logic page_cache_disable,
	output logic page_write_through,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic [bcs_pkg::PAR_W-1:0] data_parity,
	input wire logic burst_ready_in_n,
	input wire logic next_address_request_n,
	input wire logic backoff_request_n,
	input wire logic cache_enable_in_n,
	input wire logic writeback_select,
	input wire logic write_buffer_empty_n,
	output logic [bcs_pkg::BE_W-1:0] data_parity_out,
	output logic state_busy
);
	// Descriptor layout in a slot
	localparam int F_WR = 0;
	localparam int F_CODE = 1;
	localparam int F_MEM = 2;
	localparam int F_CACHE = 3;
	localparam int F_PCD = 4;
	localparam int F_PWT = 5;
	localparam int F_SER = 6;
	localparam int F_BE = 7;
	localparam int F_ADDR = 15;
	localparam int F_DATA = 44;

	bcs_pkg::bcs_state_e state, next_state;

	// Synchronised bus inputs
	logic [5:0] in_s1, in_s2;
	logic [DATA_W-1:0] din_s1, din_s2;
	logic [bcs_pkg::PAR_W-1:0] dp_s1, dp_s2;
	logic burst_ready_in, na, backoff_request, ken, wbsel, write_buffer_empty;
	logic first_beat;
	logic rsp_first;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_s1 <= 6'h3f;
			in_s2 <= 6'h3f;
			din_s1 <= '0;
			din_s2 <= '0;
			dp_s1 <= '0;
			dp_s2 <= '0;
		end else begin
			in_s1 <= {burst_ready_in_n, next_address_request_n, backoff_request_n,
				cache_enable_in_n, ~writeback_select, write_buffer_empty_n};
			in_s2 <= in_s1;
			din_s1 <= data_in;
			din_s2 <= din_s1;
			dp_s1 <= data_parity;
			dp_s2 <= dp_s1;
		end
	end

	// The first data clock still shows the pin as it stood in the clock before the strobe
	assign burst_ready_in = ~in_s2[5] && !first_beat;
	assign na = ~in_s2[4];
	assign backoff_request = ~in_s2[3];
	assign ken = ~in_s2[2];
	assign wbsel = ~in_s2[1];
	assign write_buffer_empty = ~in_s2[0];

	// Pending request, with second half of a split held for issue right after
	logic pend_valid;
	logic [bcs_pkg::SLOT_W-1:0] pend_desc;
	logic split_hold;
	logic [bcs_pkg::SLOT_W-1:0] split_desc;
	logic ser_wait;
	logic issue;
	logic issue_ok;

	function automatic logic [bcs_pkg::SLOT_W-1:0] pack_desc(
		input logic [bcs_pkg::ADDR_HI:bcs_pkg::ADDR_LO] a,
		input logic [bcs_pkg::BE_W-1:0] be,
		input logic [DATA_W-1:0] d,
		input logic [6:0] ctl
	);
		pack_desc = {4'h0, d[DATA_W-1:DATA_W-64], a, be, ctl};
	endfunction : pack_desc

	// Direction of the cycle a descriptor describes
	function automatic logic desc_wr(input logic [bcs_pkg::SLOT_W-1:0] d);
		desc_wr = d[F_WR];
	endfunction : desc_wr

	logic [6:0] req_ctl;
	assign req_ctl = {req_serialize, req_pwt, req_pcd, req_cache, req_mem, req_code, req_write};

	assign req_ready = !pend_valid && !split_hold;
	assign issue_ok = !ser_wait;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_valid <= 1'b0;
			pend_desc <= '0;
			split_hold <= 1'b0;
			split_desc <= '0;
		end else if (issue) begin
			// Upper half goes out as the very next cycle
			pend_valid <= split_hold;
			pend_desc <= split_desc;
			split_hold <= 1'b0;
		end else if (req_valid && req_ready) begin
			pend_valid <= 1'b1;
			pend_desc <= pack_desc(req_addr, req_be, req_wdata, req_ctl);
			split_hold <= req_split;
			split_desc <= pack_desc(req_addr + 29'h1, req_be_hi, req_wdata_hi, req_ctl);
		end
	end

	// Outstanding cycles: slot cur holds the cycle in data phase
	logic cur_ptr;
	logic [bcs_pkg::SLOT_W-1:0] cur_desc;
	logic [bcs_pkg::SLOT_W-1:0] nxt_desc;
	logic [2:0] beats_left;
	logic [2:0] next_beats;
	logic last_burst_ready_in;
	logic burst_cyc;
	logic dir_change;
	logic na_seen;
	logic ptr_swap;

	// A first ready that turns the cycle into a burst is not its last
	assign last_burst_ready_in = burst_ready_in && beats_left == 3'h1 && !(rsp_first && burst_cyc);
	// In pipeline address the new cycle still sits in the pending register
	assign dir_change = desc_wr(cur_desc) != desc_wr(state == bcs_pkg::BCS_PADDR ? pend_desc
		: nxt_desc);
	assign ptr_swap = last_burst_ready_in && (state == bcs_pkg::BCS_PADDR || state == bcs_pkg::BCS_PDATA);

	bcs_slot_mem #(
		.WIDTH(bcs_pkg::SLOT_W)
	) u_slots (
		.clk(clk),
		.resetn(resetn),
		.wr_en(issue),
		.wr_addr(state == bcs_pkg::BCS_PADDR ? ~cur_ptr : cur_ptr),
		.wr_data(pend_desc),
		// Read ahead so the next cycle's descriptor is out right after the swap
		.rd_addr(cur_ptr ^ ptr_swap),
		.rd_data(cur_desc)
	);

	// Pipelined descriptor copy, for the direction check
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nxt_desc <= '0;
		end else if (issue) begin
			nxt_desc <= pend_desc;
		end
	end

	assign issue = (state == bcs_pkg::BCS_ADDR) || (state == bcs_pkg::BCS_PADDR);

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			bcs_pkg::BCS_IDLE: begin
				if (pend_valid && issue_ok) begin
					next_state = bcs_pkg::BCS_ADDR;
				end
			end
			bcs_pkg::BCS_ADDR: begin
				next_state = bcs_pkg::BCS_DATA;
			end
			bcs_pkg::BCS_DATA: begin
				if (first_beat) begin
					next_state = bcs_pkg::BCS_DATA;
				end else if (last_burst_ready_in) begin
					next_state = bcs_pkg::BCS_IDLE;
				end else if (na) begin
					next_state = bcs_pkg::BCS_NAREQ;
				end
			end
			bcs_pkg::BCS_NAREQ: begin
				if (last_burst_ready_in) begin
					next_state = (pend_valid && issue_ok) ? bcs_pkg::BCS_ADDR
						: bcs_pkg::BCS_IDLE;
				end else if (pend_valid && issue_ok) begin
					next_state = bcs_pkg::BCS_PADDR;
				end
			end
			bcs_pkg::BCS_PADDR: begin
				// next-address is not looked at here
				if (last_burst_ready_in) begin
					next_state = dir_change ? bcs_pkg::BCS_TURN
						: bcs_pkg::BCS_DATA;
				end else begin
					next_state = bcs_pkg::BCS_PDATA;
				end
			end
			bcs_pkg::BCS_PDATA: begin
				if (last_burst_ready_in) begin
					if (dir_change) begin
						next_state = bcs_pkg::BCS_TURN;
					end else if (na_seen || na) begin
						next_state = bcs_pkg::BCS_NAREQ;
					end else begin
						next_state = bcs_pkg::BCS_DATA;
					end
				end
			end
			bcs_pkg::BCS_TURN: begin
				next_state = na ? bcs_pkg::BCS_NAREQ : bcs_pkg::BCS_DATA;
			end
			default: begin
				next_state = bcs_pkg::BCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= bcs_pkg::BCS_IDLE;
		end else if (backoff_request) begin
			state <= bcs_pkg::BCS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Current-cycle pointer swaps when the pipelined cycle takes the data phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur_ptr <= 1'b0;
		end else if (last_burst_ready_in && (state == bcs_pkg::BCS_PADDR
				|| state == bcs_pkg::BCS_PDATA)) begin
			cur_ptr <= ~cur_ptr;
		end
	end

	// NA seen in pipeline data carries over to a pipelined cycle of the same direction
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			na_seen <= 1'b0;
		end else if (state != bcs_pkg::BCS_PDATA || last_burst_ready_in) begin
			na_seen <= 1'b0;
		end else if (na) begin
			na_seen <= 1'b1;
		end
	end

	// No ready is taken in the first data clock after a non-pipelined strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_beat <= 1'b0;
		end else begin
			first_beat <= state == bcs_pkg::BCS_ADDR;
		end
	end

	// Beat count: burst when a read with cache intent and no page cache disable sees cache enable on first ready
	assign burst_cyc = !desc_wr(cur_desc) && cur_desc[F_CACHE] && ken
		&& !(cur_desc[F_PCD]);

	always_comb begin
		next_beats = beats_left;
		if (burst_ready_in && beats_left != 3'h0) begin
			if (beats_left == bcs_pkg::SINGLE_BEATS && rsp_first && burst_cyc) begin
				next_beats = bcs_pkg::BURST_BEATS - 3'h1;
			end else begin
				next_beats = beats_left - 3'h1;
			end
		end
	end

	logic data_phase;
	assign data_phase = state == bcs_pkg::BCS_DATA || state == bcs_pkg::BCS_NAREQ
		|| state == bcs_pkg::BCS_PADDR || state == bcs_pkg::BCS_PDATA;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			beats_left <= 3'h0;
			rsp_first <= 1'b0;
		end else if (backoff_request) begin
			beats_left <= 3'h0;
			rsp_first <= 1'b0;
		end else if (state == bcs_pkg::BCS_ADDR) begin
			beats_left <= bcs_pkg::SINGLE_BEATS;
			rsp_first <= 1'b1;
		end else if (last_burst_ready_in && !(beats_left == bcs_pkg::SINGLE_BEATS && rsp_first
				&& burst_cyc) && (state == bcs_pkg::BCS_PADDR
				|| state == bcs_pkg::BCS_PDATA)) begin
			beats_left <= bcs_pkg::SINGLE_BEATS;
			rsp_first <= 1'b1;
		end else if (data_phase && burst_ready_in) begin
			beats_left <= next_beats;
			rsp_first <= 1'b0;
		end
	end

	// Serializing write: hold further cycles until buffer empty is seen
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ser_wait <= 1'b0;
		end else if (issue && pend_desc[F_SER] && desc_wr(pend_desc)) begin
			ser_wait <= 1'b1;
		end else if (write_buffer_empty && state == bcs_pkg::BCS_IDLE) begin
			ser_wait <= 1'b0;
		end
	end

	// Response to the core
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_parity <= '0;
			rsp_cacheable <= 1'b0;
			rsp_writeback <= 1'b0;
			rsp_last <= 1'b0;
		end else begin
			rsp_valid <= data_phase && burst_ready_in && !backoff_request;
			rsp_rdata <= din_s2;
			rsp_parity <= dp_s2;
			// Decided on the first ready and held for the rest of the burst
			if (burst_ready_in && rsp_first) begin
				rsp_cacheable <= burst_cyc;
			end
			rsp_writeback <= wbsel;
			rsp_last <= last_burst_ready_in && !(rsp_first && burst_cyc);
		end
	end

	// Bus drive: address group loaded in strobe states and enabled until idle, data for writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			address_strobe_n <= 1'b1;
			addr_out <= '0;
			addr_oe <= 1'b0;
			byte_enables_n <= 8'hff;
			data_code_select <= 1'b0;
			write_read_select <= 1'b0;
			memory_io_select <= 1'b0;
			cacheable_intent_n <= 1'b1;
			page_cache_disable <= 1'b0;
			page_write_through <= 1'b0;
		end else if (!backoff_request && (next_state == bcs_pkg::BCS_ADDR
				|| next_state == bcs_pkg::BCS_PADDR)) begin
			address_strobe_n <= 1'b0;
			addr_out <= pend_desc[F_ADDR +: 29];
			addr_oe <= 1'b1;
			byte_enables_n <= ~pend_desc[F_BE +: 8];
			data_code_select <= pend_desc[F_CODE];
			write_read_select <= pend_desc[F_WR];
			memory_io_select <= pend_desc[F_MEM];
			cacheable_intent_n <= ~pend_desc[F_CACHE];
			page_cache_disable <= pend_desc[F_PCD];
			page_write_through <= pend_desc[F_PWT];
		end else begin
			address_strobe_n <= 1'b1;
			addr_oe <= !backoff_request && next_state != bcs_pkg::BCS_IDLE;
		end
	end

	// Write data from the edge after the strobe; off during turnaround
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out <= '0;
			data_oe <= 1'b0;
			data_parity_out <= '0;
		end else begin
			data_oe <= !backoff_request && desc_wr(state == bcs_pkg::BCS_ADDR ? pend_desc : cur_desc)
				&& (next_state == bcs_pkg::BCS_DATA || next_state == bcs_pkg::BCS_NAREQ
				|| next_state == bcs_pkg::BCS_PDATA
				|| next_state == bcs_pkg::BCS_PADDR);
			data_out <= (state == bcs_pkg::BCS_ADDR) ? pend_desc[F_DATA +: 64]
				: cur_desc[F_DATA +: 64];
			data_parity_out <= '0;
		end
	end

	assign state_busy = state != bcs_pkg::BCS_IDLE;
endmodule : bcs_sequencer

// *** bcs_seq_props.sv ***
// Bus-side timing checker for the cycle sequencer
module bcs_seq_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic address_strobe_n,
	input wire logic addr_oe,
	input wire logic [bcs_pkg::BE_W-1:0] byte_enables_n,
	input wire logic write_read_select,
	input wire logic cacheable_intent_n,
	input wire logic data_oe,
	input wire logic burst_ready_in_n,
	input wire logic next_address_request_n,
	input wire logic backoff_request_n,
	input wire logic rsp_valid,
	input wire logic rsp_cacheable,
	input wire logic state_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_start;
		$fell(address_strobe_n);
	endsequence
	sequence s_last;
		!burst_ready_in_n && next_address_request_n;
	endsequence
	strobe_one_clk_a: assert property (s_start |=> address_strobe_n)
		else $error("address strobe held past one clock");
	backoff_idle_a: assert property ((!backoff_request_n)[*5] |-> address_strobe_n && !state_busy)
		else $error("backoff did not force idle");
	write_data_a: assert property (s_start ##0 write_read_select |=> data_oe)
		else $error("write data not driven after strobe");
	idle_quiet_a: assert property (!state_busy |-> !data_oe && address_strobe_n)
		else $error("bus driven while idle");
	ready_gap_a: assert property (s_last |=> address_strobe_n[*2])
		else $error("strobe too soon after ready");
	strobe_group_a: assert property (!address_strobe_n |-> addr_oe && byte_enables_n != 8'hff)
		else $error("strobe without address or byte enables");
	ready_taken_a: assert property (!burst_ready_in_n && state_busy |-> ##[2:4] rsp_valid)
		else $error("ready beat not taken");
	cache_agree_a: assert property (rsp_valid && rsp_cacheable |-> !cacheable_intent_n)
		else $error("cacheable without intent");
endmodule : bcs_seq_props

bind bcs_sequencer bcs_seq_props bcs_seq_props_i (.clk, .resetn, .address_strobe_n, .addr_oe,
	.byte_enables_n, .write_read_select, .cacheable_intent_n, .data_oe, .burst_ready_in_n,
	.next_address_request_n, .backoff_request_n, .rsp_valid, .rsp_cacheable, .state_busy);

// *** bcs_sys_model.sv ***
// Behavioural system logic answering the sequencer's bus cycles
module bcs_sys_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic address_strobe_n,
	input wire logic cacheable_intent_n,
	input wire logic backoff_request_n,
	input wire logic ken_en,
	input wire logic na_en,
	input wire logic [7:0] wait_cyc,
	output logic burst_ready_in_n,
	output logic next_address_request_n,
	output logic cache_enable_in_n,
	output logic writeback_select,
	output logic [63:0] data_in,
	output logic [7:0] data_parity
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdef;
	logic q[$];
	int cnt;
	int beat;
	always @(posedge clk or negedge resetn) begin
		if (!resetn || !backoff_request_n) begin
			q = {};
			cnt = 0;
			beat = 0;
			burst_ready_in_n <= 1'b1;
			next_address_request_n <= 1'b1;
			cache_enable_in_n <= 1'b1;
			writeback_select <= 1'b1;
			data_in <= PAT;
			data_parity <= 8'ha5;
		end else begin
			burst_ready_in_n <= 1'b1;
			next_address_request_n <= 1'b1;
			cache_enable_in_n <= 1'b1;
			// Released data toggles so a stale sample never looks valid
			data_in <= ~data_in;
			data_parity <= ~data_parity;
			if (q.size() > 0) begin
				cnt++;
				if (na_en && cnt == 1 && beat == 0 && q.size() == 1)
					next_address_request_n <= 1'b0;
				if (cnt > int'(wait_cyc)) begin
					burst_ready_in_n <= 1'b0;
					cache_enable_in_n <= !(ken_en && beat == 0);
					data_in <= PAT + 64'(beat);
					data_parity <= 8'h5a;
					cnt = 0;
					beat++;
					if (beat == (q[0] ? 4 : 1)) begin
						void'(q.pop_front());
						beat = 0;
					end
				end
			end
			if (!address_strobe_n)
				q.push_back(ken_en && !cacheable_intent_n);
		end
	end
endmodule : bcs_sys_model

// *** tb_top.sv ***
// Self-checking bench for the cycle sequencer against the system model
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdef;
	logic clk = 0;
	logic resetn = 0;
	logic req_valid = 0, req_split = 0, req_write = 0, req_code = 0, req_mem = 1;
	logic req_cache = 0, req_pcd = 0, req_pwt = 0, req_serialize = 0;
	logic [31:3] req_addr = '0;
	logic [7:0] req_be = 8'h0f, req_be_hi = 8'h00;
	logic [63:0] req_wdata = '0, req_wdata_hi = '0;
	logic backoff_request_n = 1, write_buffer_empty_n = 0, ken_en = 0, na_en = 0;
	logic [7:0] wait_cyc = 0;
	logic req_ready, rsp_valid, rsp_cacheable, rsp_writeback, rsp_last, address_strobe_n;
	logic addr_oe, data_code_select, write_read_select, memory_io_select, cacheable_intent_n;
	logic page_cache_disable, page_write_through, data_oe, state_busy, writeback_select;
	logic burst_ready_in_n, next_address_request_n, cache_enable_in_n;
	logic [63:0] rsp_rdata, data_out, data_in, wd_seen;
	logic [7:0] rsp_parity, byte_enables_n, data_parity, data_parity_out;
	logic [31:3] addr_out;
	logic [31:3] ads_addr[$];
	logic [7:0] ads_be[$];
	int n_ads = 0, n_fail = 0, num_checks = 0;
	bcs_sequencer bcs_sequencer_i (.*);
	bcs_sys_model bcs_sys_model_i (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (!address_strobe_n) begin
			n_ads++;
			ads_addr.push_back(addr_out);
			ads_be.push_back(byte_enables_n);
		end
		if (data_oe)
			wd_seen = data_out;
	end
	function automatic logic [63:0] wpat(input logic [31:3] a);
		return {a, 3'h0, a, 3'h0};
	endfunction : wpat
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic tmo();
		n_fail++;
		$display("Error %0t: wait ran out", $time);
		finish_test();
	endtask : tmo
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic send(input logic [31:3] a, input logic w, input logic s, input logic c);
		int i;
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr <= a;
		req_write <= w;
		req_split <= s;
		req_cache <= c;
		req_wdata <= wpat(a);
		req_wdata_hi <= ~wpat(a);
		i = 0;
		do @(negedge clk); while (req_ready !== 1'b1 && ++i < 200);
		if (i >= 200)
			tmo();
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : send
	task automatic get_rsp();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1;
		end while (rsp_valid !== 1'b1 && ++i < 300);
		if (i >= 300)
			tmo();
	endtask : get_rsp
	task automatic settle();
		int k;
		k = 0;
		for (int i = 0; i < 300 && k < 10; i++) begin
			@(posedge clk);
			#1;
			k = (state_busy === 1'b0) ? k + 1 : 0;
		end
		if (k < 10)
			tmo();
	endtask : settle
	task automatic t_rdwr();
		int n0;
		n0 = n_ads;
		send(29'h100, 1'b0, 1'b0, 1'b0);
		get_rsp();
		check(rsp_rdata, PAT);
		check(64'(rsp_parity), 64'h5a);
		check(64'(rsp_last), 64'h1);
		check(64'(ads_addr[n0]), 64'h100);
		check(64'(ads_be[n0]), 64'hf0);
		check(64'(memory_io_select), 64'h1);
		check(64'(data_code_select), 64'h0);
		check(64'(rsp_writeback), 64'h1);
		send(29'h101, 1'b1, 1'b0, 1'b0);
		get_rsp();
		check(wd_seen, wpat(29'h101));
		check(64'(n_ads - n0), 64'h2);
		settle();
		$display("read and write done");
	endtask : t_rdwr
	task automatic t_burst();
		@(posedge clk);
		ken_en <= 1'b1;
		send(29'h104, 1'b0, 1'b0, 1'b1);
		for (int k = 0; k < 4; k++) begin
			get_rsp();
			check(rsp_rdata, PAT + 64'(k));
			check(64'(rsp_last), 64'(k == 3));
			check(64'(rsp_cacheable), 64'h1);
		end
		settle();
		// Disabled page with no intent stays single even though the system agrees
		req_pcd <= 1'b1;
		send(29'h104, 1'b0, 1'b0, 1'b0);
		get_rsp();
		check(64'(rsp_last), 64'h1);
		check(64'(rsp_cacheable), 64'h0);
		check(64'(page_cache_disable), 64'h1);
		settle();
		req_pcd <= 1'b0;
		ken_en <= 1'b0;
		$display("burst done");
	endtask : t_burst
	task automatic t_split();
		int n0;
		n0 = n_ads;
		req_be <= 8'hf0;
		req_be_hi <= 8'h0f;
		send(29'h108, 1'b0, 1'b1, 1'b0);
		get_rsp();
		get_rsp();
		check(64'(n_ads - n0), 64'h2);
		check(64'(ads_addr[n0 + 1]), 64'h109);
		check(64'(ads_be[n0]), 64'h0f);
		check(64'(ads_be[n0 + 1]), 64'hf0);
		settle();
		req_be <= 8'h0f;
		$display("split done");
	endtask : t_split
	task automatic t_pipe();
		int n0;
		n0 = n_ads;
		na_en <= 1'b1;
		wait_cyc <= 8'h06;
		send(29'h10c, 1'b1, 1'b0, 1'b0);
		send(29'h110, 1'b0, 1'b0, 1'b0);
		get_rsp();
		check(64'(n_ads - n0), 64'h2);
		check(wd_seen, wpat(29'h10c));
		get_rsp();
		check(rsp_rdata, PAT);
		settle();
		na_en <= 1'b0;
		wait_cyc <= 8'h00;
		$display("pipeline done");
	endtask : t_pipe
	task automatic t_backoff_request();
		wait_cyc <= 8'h1e;
		send(29'h114, 1'b0, 1'b0, 1'b0);
		backoff_request_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		check(64'(state_busy), 64'h0);
		check(64'(address_strobe_n), 64'h1);
		@(posedge clk);
		backoff_request_n <= 1'b1;
		wait_cyc <= 8'h00;
		settle();
		$display("backoff done");
	endtask : t_backoff_request
	task automatic t_ser();
		int n0;
		write_buffer_empty_n <= 1'b1;
		req_serialize <= 1'b1;
		send(29'h118, 1'b1, 1'b0, 1'b0);
		req_serialize <= 1'b0;
		get_rsp();
		n0 = n_ads;
		send(29'h11c, 1'b0, 1'b0, 1'b0);
		repeat (12) @(posedge clk);
		check(64'(n_ads - n0), 64'h0);
		write_buffer_empty_n <= 1'b0;
		get_rsp();
		check(64'(n_ads - n0), 64'h1);
		settle();
		$display("serialize done");
	endtask : t_ser
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_rdwr();
		t_burst();
		t_split();
		t_pipe();
		t_backoff_request();
		t_ser();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		tmo();
	end
endmodule : tb_top
